/* File: logic/pmc_power_mode_controller.sv */
// The plain strobed port and the address map are this design's own decisions.
`include "pmc_cfg.svh"

// What this block does
// - Power control bit 0 enters idle
// - Enabled interrupt or reset leaves idle
// - Power control bit 1 enters stop; reset exits
// - Oscillator bit 5 stops internal oscillator
// - Port events or comparator low exit suspend
// - Suspend/stop halt CPU, interrupts, timers, oscillator
// - Comparator edge selectable, wakes idle/suspend
module pmc_power_mode_controller
    import pmc_pkg::*;
(
    // Clock and synchronous reset
    input  wire logic       mclk,
    input  wire logic       rst_b,
    // Register port
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // Wake sources, same clock domain
    input  wire logic       irq_pending,
    input  wire logic       port0_match,
    input  wire logic       port1_match,
    // Comparator output, asynchronous
    input  wire logic       comparator_sync_output,
    // Gating outputs
    output logic            cpu_run,
    output logic            system_clock_en,
    output logic            periph_clk_en,
    output logic            int_osc_en,
    output logic            irq_timers_en,
    output logic            cmp_irq,
    output logic            pmc_irq
);

    ////////////////////////////////////////////////////////////////////////
    // State
    pmc_mode_t   mode_q,   mode_d;     // Current mode
    logic [7:0]  osc_q,    osc_d;      // Oscillator control, bit 0 = clock source internal
    logic [7:0]  stat_q,   stat_d;     // Sticky event status
    logic [7:0]  mask_q,   mask_d;     // Interrupt mask
    logic [7:0]  cmpc_q,   cmpc_d;     // Comparator control
    logic [7:0]  rdata_q,  rdata_d;    // Registered read data
    logic        cmp_s1_q, cmp_s2_q;   // Comparator synchroniser
    logic        cmp_old_q;            // Previous synchronised level
    logic        cmp_irq_q, cmp_irq_d; // Comparator interrupt pulse

    // Decode one address strobe; used by writes and reads
    function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
        return a == r;
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////
    // Comparator synchroniser: first stage read by second only
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            cmp_s1_q  <= 1'b1;
            cmp_s2_q  <= 1'b1;
            cmp_old_q <= 1'b1;
        end
        else
        begin
            cmp_s1_q  <= comparator_sync_output;
            cmp_s2_q  <= cmp_s1_q;
            cmp_old_q <= cmp_s2_q;
        end
    end

    // Edge terms of the synchronised comparator
    logic cmp_rise, cmp_fall, cmp_edge, cmp_low_wake, susp_wake, idle_wake;
    assign cmp_rise     = cmp_s2_q & ~cmp_old_q;
    assign cmp_fall     = ~cmp_s2_q & cmp_old_q;
    // Edge selection: rising, falling or both
    assign cmp_edge     = cmpc_q[`PMC_CMP_EN_BIT]
                        & ((cmpc_q[`PMC_CMP_RISE_BIT] & cmp_rise)
                        | (cmpc_q[`PMC_CMP_FALL_BIT] & cmp_fall));
    // Enabled comparator at logic low wakes suspend
    assign cmp_low_wake = cmpc_q[`PMC_CMP_EN_BIT] & ~cmp_s2_q;
    assign susp_wake    = port0_match | port1_match | cmp_low_wake | cmp_edge;
    // Any enabled interrupt, comparator edge included, ends idle
    assign idle_wake    = irq_pending | cmp_edge;

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic for mode, registers and status
    always_comb
    begin
        mode_d    = mode_q;
        osc_d     = osc_q;
        mask_d    = mask_q;
        cmpc_d    = cmpc_q;
        stat_d    = stat_q;
        rdata_d   = 8'h00;
        cmp_irq_d = cmp_edge;
        // Mode sequencing; only reset leaves stop, since rst_b dominates
        case (mode_q)
            PMC_ACTIVE:
            begin
                // Stop has priority over idle when both bits are written
                if (reg_wr && hit(reg_addr, `PMC_ADDR_PWR))
                begin
                    if (reg_wdata[`PMC_PWR_STOP_BIT])
                        mode_d = PMC_STOP;
                    else if (reg_wdata[`PMC_PWR_IDLE_BIT])
                        mode_d = PMC_IDLE;
                end
                else if (reg_wr && hit(reg_addr, `PMC_ADDR_OSC)
                         && reg_wdata[`PMC_OSC_SUSP_BIT])
                    mode_d = PMC_SUSPEND;
            end
            PMC_IDLE:
            begin
                // Idle bit reads back zero once active again
                if (idle_wake)
                begin
                    mode_d = PMC_ACTIVE;
                    stat_d[`PMC_ST_WAKE_IDLE] = 1'b1;
                end
            end
            PMC_SUSPEND:
            begin
                if (susp_wake)
                begin
                    mode_d = PMC_ACTIVE;
                    stat_d[`PMC_ST_WAKE_SUSP] = 1'b1;
                end
            end
            PMC_STOP:
                mode_d = PMC_STOP;
            default:
                mode_d = PMC_ACTIVE;
        endcase
        // Register writes; suspend bit is a strobe and is not stored
        if (reg_wr)
        begin
            if (hit(reg_addr, `PMC_ADDR_OSC))
                osc_d = reg_wdata & ~(8'h01 << `PMC_OSC_SUSP_BIT);
            if (hit(reg_addr, `PMC_ADDR_MASK))
                mask_d = reg_wdata;
            if (hit(reg_addr, `PMC_ADDR_CMP))
                cmpc_d = reg_wdata;
        end
        // Reads; status clears on read, but new events win
        if (reg_rd)
        begin
            if (hit(reg_addr, `PMC_ADDR_PWR))
                rdata_d = {6'h00, mode_q == PMC_STOP, mode_q == PMC_IDLE};
            else if (hit(reg_addr, `PMC_ADDR_OSC))
                rdata_d = osc_q;
            else if (hit(reg_addr, `PMC_ADDR_STATUS))
            begin
                rdata_d = stat_q;
                stat_d  = 8'h00;
                if (mode_q == PMC_IDLE && idle_wake)
                    stat_d[`PMC_ST_WAKE_IDLE] = 1'b1;
                if (mode_q == PMC_SUSPEND && susp_wake)
                    stat_d[`PMC_ST_WAKE_SUSP] = 1'b1;
            end
            else if (hit(reg_addr, `PMC_ADDR_MASK))
                rdata_d = mask_q;
            else if (hit(reg_addr, `PMC_ADDR_CMP))
                rdata_d = cmpc_q;
            else if (hit(reg_addr, `PMC_ADDR_MODE))
                rdata_d = {6'h00, mode_q};
            else
                rdata_d = 8'h00;
        end
        if (cmp_edge)
            stat_d[`PMC_ST_CMP_EDGE] = 1'b1;
    end

    ////////////////////////////////////////////////////////////////////////
    // Registers only
    always_ff @(posedge mclk)
    begin
        if (!rst_b)
        begin
            mode_q    <= PMC_ACTIVE;
            osc_q     <= `PMC_OSC_RESET;
            mask_q    <= `PMC_MASK_RESET;
            cmpc_q    <= `PMC_CMP_RESET;
            stat_q    <= 8'h00;
            rdata_q   <= 8'h00;
            cmp_irq_q <= 1'b0;
        end
        else
        begin
            mode_q    <= mode_d;
            osc_q     <= osc_d;
            mask_q    <= mask_d;
            cmpc_q    <= cmpc_d;
            stat_q    <= stat_d;
            rdata_q   <= rdata_d;
            cmp_irq_q <= cmp_irq_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Gating outputs
    logic halted, from_int;
    assign halted          = (mode_q == PMC_SUSPEND) || (mode_q == PMC_STOP);
    assign from_int        = osc_q[`PMC_OSC_SRC_BIT];
    assign cpu_run         = (mode_q == PMC_ACTIVE);
    // Stop kills the system clock; suspend does so if clocked internally
    assign system_clock_en = !(mode_q == PMC_STOP) && !(mode_q == PMC_SUSPEND && from_int);
    assign periph_clk_en   = system_clock_en;
    assign int_osc_en      = !halted;
    assign irq_timers_en   = !halted;
    assign cmp_irq         = cmp_irq_q;
    assign pmc_irq         = |(stat_q & mask_q);
    assign reg_rdata       = rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    property p_idle_enter;
        @(posedge mclk) disable iff (!rst_b)
        (mode_q == PMC_ACTIVE && reg_wr && reg_addr == `PMC_ADDR_PWR
         && reg_wdata[1:0] == 2'b01) |=> (mode_q == PMC_IDLE && !cpu_run && system_clock_en);
    endproperty
    a_idle_enter: assert property (p_idle_enter) else $error("idle not entered");

    property p_idle_exit;
        @(posedge mclk) disable iff (!rst_b)
        (mode_q == PMC_IDLE && irq_pending) |=> (mode_q == PMC_ACTIVE && cpu_run);
    endproperty
    a_idle_exit: assert property (p_idle_exit) else $error("idle not left on interrupt");

    // Sampled rst_b keeps the release edge of a one-cycle reset out of the antecedent
    property p_stop_hold;
        @(posedge mclk) disable iff (!rst_b)
        (rst_b && mode_q == PMC_STOP) |=> (mode_q == PMC_STOP && !system_clock_en)[*2];
    endproperty
    a_stop_hold: assert property (p_stop_hold) else $error("stop left without reset");

    property p_susp_clk;
        @(posedge mclk) disable iff (!rst_b)
        (mode_q == PMC_SUSPEND && osc_q[0]) |-> (!system_clock_en && !periph_clk_en);
    endproperty
    a_susp_clk: assert property (p_susp_clk) else $error("clock runs in suspend");

    property p_susp_exit;
        @(posedge mclk) disable iff (!rst_b)
        (mode_q == PMC_SUSPEND && (port0_match || port1_match)) |=> mode_q == PMC_ACTIVE;
    endproperty
    a_susp_exit: assert property (p_susp_exit) else $error("suspend not left");

    property p_halt;
        @(posedge mclk) disable iff (!rst_b)
        (mode_q == PMC_SUSPEND || mode_q == PMC_STOP)
        |-> (!cpu_run && !int_osc_en && !irq_timers_en);
    endproperty
    a_halt: assert property (p_halt) else $error("halt gating wrong");

    property p_cmp_edge;
        @(posedge mclk) disable iff (!rst_b)
        (rst_b && cmpc_q[2:0] == 3'b011 && $rose(cmp_s2_q)) |=> cmp_irq ##1 !cmp_irq;
    endproperty
    a_cmp_edge: assert property (p_cmp_edge) else $error("rising edge missed");

    // Any read of the power control register while active shows both request bits clear
    property p_self_clear;
        @(posedge mclk) disable iff (!rst_b)
        (mode_q == PMC_ACTIVE && reg_rd && reg_addr == `PMC_ADDR_PWR)
        |=> reg_rdata[1:0] == 2'b00;
    endproperty
    a_self_clear: assert property (p_self_clear) else $error("idle bit not cleared");

    // Suspend strobe halts the internal oscillator on the next cycle
    property p_susp_enter;
        @(posedge mclk) disable iff (!rst_b)
        (rst_b && mode_q == PMC_ACTIVE && reg_wr && reg_addr == `PMC_ADDR_OSC
         && reg_wdata[`PMC_OSC_SUSP_BIT]) |=> (mode_q == PMC_SUSPEND && !int_osc_en);
    endproperty
    a_susp_enter: assert property (p_susp_enter) else $error("suspend not entered");

    // The wake is logged even when a status read lands on the same edge
    property p_idle_stat;
        @(posedge mclk) disable iff (!rst_b)
        (rst_b && mode_q == PMC_IDLE && irq_pending) |=> stat_q[`PMC_ST_WAKE_IDLE];
    endproperty
    a_idle_stat: assert property (p_idle_stat) else $error("wake not logged");

    // Enabled comparator at logic low ends suspend one cycle later
    property p_susp_cmp_low;
        @(posedge mclk) disable iff (!rst_b)
        (rst_b && mode_q == PMC_SUSPEND && cmpc_q[`PMC_CMP_EN_BIT] && !cmp_s2_q)
        |=> mode_q == PMC_ACTIVE;
    endproperty
    a_susp_cmp_low: assert property (p_susp_cmp_low) else $error("low wake missed");

    // Falling edge selection gives exactly one pulse
    property p_cmp_fall;
        @(posedge mclk) disable iff (!rst_b)
        (rst_b && cmpc_q[2:0] == 3'b101 && $fell(cmp_s2_q)) |=> cmp_irq ##1 !cmp_irq;
    endproperty
    a_cmp_fall: assert property (p_cmp_fall) else $error("falling edge missed");

    // A selected comparator edge is a wake source for idle
    property p_idle_cmp_wake;
        @(posedge mclk) disable iff (!rst_b)
        (rst_b && mode_q == PMC_IDLE && cmpc_q[2:0] == 3'b011 && $rose(cmp_s2_q))
        |=> mode_q == PMC_ACTIVE;
    endproperty
    a_idle_cmp_wake: assert property (p_idle_cmp_wake) else $error("no edge wake");

endmodule : pmc_power_mode_controller

/* File: logic/pmc_cfg.svh */
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH

// Register addresses on the plain register port
`define PMC_ADDR_PWR      4'h0
`define PMC_ADDR_OSC      4'h1
`define PMC_ADDR_STATUS   4'h2
`define PMC_ADDR_MASK     4'h3
`define PMC_ADDR_CMP      4'h4
`define PMC_ADDR_MODE     4'h5

// Field positions
`define PMC_PWR_IDLE_BIT  0
`define PMC_PWR_STOP_BIT  1
`define PMC_OSC_SUSP_BIT  5
`define PMC_OSC_SRC_BIT   0
`define PMC_CMP_EN_BIT    0
`define PMC_CMP_RISE_BIT  1
`define PMC_CMP_FALL_BIT  2

// Status bits
`define PMC_ST_WAKE_IDLE  0
`define PMC_ST_WAKE_SUSP  1
`define PMC_ST_CMP_EDGE   2

// Reset values
`define PMC_OSC_RESET     8'h01
`define PMC_MASK_RESET    8'h00
`define PMC_CMP_RESET     8'h00

// Least debug clock, kHz, and clock rate, kHz
`define PMC_DBG_MIN_KHZ   32
`define PMC_CLK_KHZ       10000

`endif

/* File: logic/pmc_pkg.sv */
package pmc_pkg;

    // Operating modes
    typedef enum logic [1:0] {
        PMC_ACTIVE,
        PMC_IDLE,
        PMC_SUSPEND,
        PMC_STOP
    } pmc_mode_t;

endpackage : pmc_pkg

/* File: sim/pmc_power_mode_controller_tb.sv */
`include "pmc_cfg.svh"

module pmc_power_mode_controller_tb
    import pmc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////////////////////////////////////////
    // Ports of the block and bench state
    logic        mclk                   = 1'b0;
    logic        rst_b                  = 1'b0;
    logic [3:0]  reg_addr               = 4'h0;
    logic [7:0]  reg_wdata              = 8'h00;
    logic        reg_wr                 = 1'b0;
    logic        reg_rd                 = 1'b0;
    logic [7:0]  reg_rdata;
    logic        irq_pending            = 1'b0;
    logic        port0_match            = 1'b0;
    logic        port1_match            = 1'b0;
    logic        comparator_sync_output = 1'b1;
    logic        cpu_run;
    logic        system_clock_en;
    logic        periph_clk_en;
    logic        int_osc_en;
    logic        irq_timers_en;
    logic        cmp_irq;
    logic        pmc_irq;
    int          fails                  = 0;
    int          cmp_count              = 0;
    logic [7:0]  pulses                 = 8'h00;
    logic [31:0] seed                   = 32'hA42F;

    // 10 MHz clock
    always #50 mclk = ~mclk;

    // Comparator pulses are counted in the background, they last one cycle
    always @(posedge mclk)
        if (cmp_irq === 1'b1)
            pulses <= pulses + 8'h01;

    pmc_power_mode_controller u_pmc_power_mode_controller (
        .mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .irq_pending(irq_pending), .port0_match(port0_match),
        .port1_match(port1_match), .comparator_sync_output(comparator_sync_output),
        .cpu_run(cpu_run), .system_clock_en(system_clock_en),
        .periph_clk_en(periph_clk_en), .int_osc_en(int_osc_en),
        .irq_timers_en(irq_timers_en), .cmp_irq(cmp_irq), .pmc_irq(pmc_irq)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Helpers
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Gating outputs packed, cpu_run at bit 6 down to pmc_irq at bit 0
    function automatic logic [7:0] outs();
        return {1'b0, cpu_run, system_clock_en, periph_clk_en, int_osc_en,
                irq_timers_en, cmp_irq, pmc_irq};
    endfunction : outs

    task automatic give_verdict();
        $display("comparisons %0d, mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : give_verdict

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            fails++;
            $display("mismatch at %0t: got %h, want %h", $time, got, exp);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        reg_addr  <= a;
        reg_wdata <= d;
        reg_wr    <= 1'b1;
        @(posedge mclk);
        reg_wr    <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge mclk);
        reg_rd   <= 1'b0;
        #1;
        d = reg_rdata;
    endtask : rd

    // Wake sources: 0 port0, 1 port1, 2 comparator low, 3 interrupt
    task automatic src(input int s, input logic v);
        @(posedge mclk);
        case (s)
            0: port0_match <= v;
            1: port1_match <= v;
            2: comparator_sync_output <= ~v;
            default: irq_pending <= v;
        endcase
    endtask : src

    // Bounded wait on the run flag; a hang ends the run
    task automatic wait_cpu(input logic exp);
        int n;
        n = 0;
        #1;
        while (cpu_run !== exp && n < 8)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (cpu_run !== exp)
        begin
            fails++;
            $display("mismatch at %0t: cpu_run wait ran out", $time);
            give_verdict();
        end
    endtask : wait_cpu

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial
    begin
        logic [7:0] d;
        logic [7:0] m;
        repeat (8) @(posedge mclk);
        rst_b <= 1'b1;
        #1 chk(outs(), 8'h7C);
        rd(`PMC_ADDR_OSC, d);    chk(d, `PMC_OSC_RESET);
        rd(`PMC_ADDR_MASK, d);   chk(d, `PMC_MASK_RESET);
        rd(`PMC_ADDR_CMP, d);    chk(d, `PMC_CMP_RESET);
        wr(4'hF, 8'hA5);
        rd(4'hF, d);             chk(d, 8'h00);
        $display("reset and map test done");
        // Idle entered and left by an interrupt, after random delays
        for (int k = 0; k < 4; k++)
        begin
            wr(`PMC_ADDR_PWR, 8'h01);
            wait_cpu(1'b0);
            chk(outs(), 8'h3C);
            rd(`PMC_ADDR_MODE, d);  chk(d, {6'h00, PMC_IDLE});
            repeat (rnd() % 4) @(posedge mclk);
            src(3, 1'b1);
            wait_cpu(1'b1);
            src(3, 1'b0);
            rd(`PMC_ADDR_PWR, d);    chk(d, 8'h00);
            rd(`PMC_ADDR_STATUS, d); chk(d, 8'h01);
            rd(`PMC_ADDR_STATUS, d); chk(d, 8'h00);
        end
        $display("idle test done");
        // Comparator edge select: rise, fall, both
        for (int e = 1; e < 4; e++)
        begin
            wr(`PMC_ADDR_CMP, 8'h01 | 8'(e << 1));
            m = pulses;
            src(2, 1'b1);
            repeat (6) @(posedge mclk);
            src(2, 1'b0);
            repeat (6) @(posedge mclk);
            #1 chk(pulses - m, (e == 3) ? 8'h02 : 8'h01);
        end
        m = 8'(rnd());
        wr(`PMC_ADDR_MASK, m);
        @(posedge mclk);
        #1 chk(pmc_irq, m[2]);
        rd(`PMC_ADDR_STATUS, d); chk(d, 8'h04);
        @(posedge mclk);
        #1 chk(pmc_irq, 1'b0);
        wr(`PMC_ADDR_MASK, 8'h00);
        $display("comparator and interrupt test done");
        // Suspend, woken by port0, port1 and comparator low, clock source internal or not
        wr(`PMC_ADDR_CMP, 8'h01);
        for (int s = 0; s < 3; s++)
        begin
            wr(`PMC_ADDR_OSC, (s == 1) ? 8'h20 : 8'h21);
            wait_cpu(1'b0);
            chk(outs(), (s == 1) ? 8'h30 : 8'h00);
            src(3, 1'b1);
            repeat (2) @(posedge mclk);
            #1 chk(cpu_run, 1'b0);
            src(3, 1'b0);
            src(s, 1'b1);
            wait_cpu(1'b1);
            src(s, 1'b0);
            rd(`PMC_ADDR_STATUS, d); chk(d, 8'h02);
        end
        wr(`PMC_ADDR_OSC, 8'h01);
        // Comparator rising edge wakes idle
        wr(`PMC_ADDR_CMP, 8'h03);
        src(2, 1'b1);
        wr(`PMC_ADDR_PWR, 8'h01);
        wait_cpu(1'b0);
        src(2, 1'b0);
        wait_cpu(1'b1);
        rd(`PMC_ADDR_STATUS, d); chk(d & 8'h04, 8'h04);
        $display("suspend test done");
        // Stop wins over idle, only reset leaves it
        wr(`PMC_ADDR_PWR, 8'h03);
        wait_cpu(1'b0);
        chk(outs(), 8'h00);
        rd(`PMC_ADDR_MODE, d);   chk(d, {6'h00, PMC_STOP});
        for (int s = 0; s < 4; s++)
            src(s, 1'b1);
        repeat (3) @(posedge mclk);
        #1 chk(cpu_run, 1'b0);
        for (int s = 0; s < 4; s++)
            src(s, 1'b0);
        @(posedge mclk);
        rst_b <= 1'b0;
        @(posedge mclk);
        rst_b <= 1'b1;
        #1 chk(outs(), 8'h7C);
        rd(`PMC_ADDR_PWR, d);    chk(d, 8'h00);
        $display("stop test done");
        give_verdict();
    end

endmodule : pmc_power_mode_controller_tb
